// *** src/rivm_pkg.sv ***
// shared constants and types for the reset and interrupt vector map
package rivm_pkg;

   localparam int RIVM_PC_W     = 13;
   localparam int RIVM_NUM_SRC  = 25;
   localparam int RIVM_VNO_W    = 5;
   localparam int RIVM_IDX_W    = 5;

   localparam logic [RIVM_VNO_W-1:0] RIVM_RESET_VEC_NO     = 5'h01;
   localparam logic [RIVM_VNO_W-1:0] RIVM_FIRST_IRQ_VEC_NO = 5'h02;
   localparam logic [RIVM_VNO_W-1:0] RIVM_LAST_IRQ_VEC_NO  = 5'h1A;

   // words per vector slot: two in the larger part, one in the smaller
   localparam int RIVM_VEC_WORDS_LARGE = 2;
   localparam int RIVM_VEC_WORDS_SMALL = 1;

   localparam logic [RIVM_PC_W-1:0] RIVM_RESET_ADDR        = 13'h0000;
   localparam logic [RIVM_PC_W-1:0] RIVM_BOOT_START_LARGE  = 13'h1C00;
   localparam logic [RIVM_PC_W-1:0] RIVM_BOOT_START_SMALL  = 13'h0C00;
   localparam logic [RIVM_PC_W-1:0] RIVM_SMALL_FIRST_RELOC = 13'h0C01;
   localparam logic [RIVM_PC_W-1:0] RIVM_SMALL_LAST_RELOC  = 13'h0C19;
   localparam logic [RIVM_PC_W-1:0] RIVM_FIRST_RELOC_OFS   = 13'h0002;

   // fuse level: low means programmed
   localparam logic RIVM_FUSE_PROGRAMMED   = 1'b0;
   localparam logic RIVM_FUSE_UNPROGRAMMED = 1'b1;

   // larger-part vector table, indexed by request line
   localparam logic [RIVM_PC_W-1:0] RIVM_VEC_ADDR [RIVM_NUM_SRC] = '{
      13'h0002, 13'h0004,                       // external requests 0, 1
      13'h0006, 13'h0008, 13'h000A, 13'h000C,   // pin change 0..2, watchdog
      13'h000E, 13'h0010, 13'h0012,             // timer 2
      13'h0014, 13'h0016, 13'h0018, 13'h001A,   // timer 1
      13'h001C, 13'h001E, 13'h0020,             // timer 0
      13'h0022,                                 // spi
      13'h0024, 13'h0026, 13'h0028,             // usart
      13'h002A, 13'h002C, 13'h002E,             // adc, eeprom, comparator
      13'h0030, 13'h0032                        // two-wire, program store
   };

   typedef enum {
      RIVM_ST_FUSE,
      RIVM_ST_RESET_FETCH,
      RIVM_ST_IDLE,
      RIVM_ST_IRQ_FETCH
   } rivm_state_e;

   typedef struct packed {
      logic                  is_reset;
      logic                  relocated;
      logic [RIVM_VNO_W-1:0] vec_no;
      logic [RIVM_PC_W-1:0]  addr;
   } rivm_fetch_s;

endpackage

// *** src/rivm_prio_enc.sv ***
// lowest-index-first priority encoder for pending requests
`timescale 1ns/10ps
module rivm_prio_enc
   import rivm_pkg::*;
#(
   parameter int N     = RIVM_NUM_SRC,
   parameter int IDX_W = RIVM_IDX_W
)
(
   input  wire logic [N-1:0]     req,
   output logic                  any,
   output logic [IDX_W-1:0]      idx,
   output logic [N-1:0]          onehot
);

   // scan downward so the lowest set bit is the last one written
   always_comb
   begin
      any    = 1'b0;
      idx    = '0;
      onehot = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (req[i])
         begin
            any    = 1'b1;
            idx    = IDX_W'(i);
            onehot = N'(1) << i;
         end
      end
   end

endmodule // rivm_prio_enc

// *** src/rivm_vector_map.sv ***
// reset and interrupt vector address generator facing the cpu fetch logic
//
// Overview of operation
// - any reset fetches vector 1, at zero with fuse unprogrammed
// - external requests 0, 1 go to 0x0002, 0x0004
// - pin change 0x0006-0x000A, watchdog 0x000C
// - timer two A, B, overflow 0x000E-0x0012
// - timer one capture, A, B, overflow 0x0014-0x001A
// - timer zero A, B, overflow 0x001C-0x0020
// - spi transfer complete goes to 0x0022
// - usart receive, empty, transmit 0x0024-0x0028
// - adc, eeprom, comparator, two-wire, store 0x002A-0x0032
// - programmed fuse starts reset at boot start
// - select bit adds boot start to vectors
// - small part boot 0xC00, vectors 0xC01-0xC19
// - irq vectors fetched only when interrupt taken
// - fuse reads 1 unprogrammed, 0 programmed
// - relocated first vector at boot plus two, plus one in the small part
`timescale 1ns/10ps
module rivm_vector_map
   import rivm_pkg::*;
#(
   parameter logic [RIVM_PC_W-1:0] BOOT_START = RIVM_BOOT_START_LARGE,
   parameter int                   VEC_WORDS  = RIVM_VEC_WORDS_LARGE,
   parameter int                   NUM_SRC    = RIVM_NUM_SRC
)
(
   input  wire logic                 mclk,
   input  wire logic                 rstn,
   input  wire logic                 boot_reset_select_fuse,
   input  wire logic                 vector_table_select_bit,
   input  wire logic                 cpu_irq_enable,
   input  wire logic [NUM_SRC-1:0]   irq_enable_mask,
   input  wire logic [NUM_SRC-1:0]   irq_req,
   input  wire logic                 fetch_ready,
   output logic                      fetch_valid,
   output rivm_fetch_s               fetch,
   output logic [NUM_SRC-1:0]        irq_ack,
   output logic                      boot_reset_active
);

   rivm_state_e              state;
   logic [NUM_SRC-1:0]       pending;
   logic                     pend_any;
   logic [RIVM_IDX_W-1:0]    win_idx;
   logic [NUM_SRC-1:0]       win_onehot;
   logic [NUM_SRC-1:0]       win_held;
   logic                     take;
   logic                     accept;
   logic                     in_fuse_phase;

   // address of a request line's slot, optionally moved to boot space
   function automatic logic [RIVM_PC_W-1:0] vec_target(
      input logic [RIVM_IDX_W-1:0] idx,
      input logic                  reloc
   );
      logic [RIVM_PC_W-1:0] ofs;
      ofs = RIVM_PC_W'((int'(idx) + int'(RIVM_FIRST_IRQ_VEC_NO)
                       - int'(RIVM_RESET_VEC_NO)) * VEC_WORDS);
      return reloc ? RIVM_PC_W'(BOOT_START + ofs) : ofs;
   endfunction

   // reset target: the select bit never moves the reset vector
   function automatic logic [RIVM_PC_W-1:0] reset_target(
      input logic fuse_level
   );
      return (fuse_level == RIVM_FUSE_PROGRAMMED) ? BOOT_START : RIVM_RESET_ADDR;
   endfunction

   assign pending       = irq_req & irq_enable_mask;
   assign in_fuse_phase = (state == RIVM_ST_FUSE);
   assign accept        = fetch_valid & fetch_ready;
   // apart from the reset fetch, only a taken interrupt produces a vector fetch
   assign take          = (state == RIVM_ST_IDLE) & cpu_irq_enable & pend_any;

   rivm_prio_enc #(
      .N     (NUM_SRC),
      .IDX_W (RIVM_IDX_W)
   ) u_prio (
      .req    (pending),
      .any    (pend_any),
      .idx    (win_idx),
      .onehot (win_onehot)
   );

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         state <= RIVM_ST_FUSE;
      else
      begin
         unique case (state)
            RIVM_ST_FUSE:
               state <= RIVM_ST_RESET_FETCH;
            RIVM_ST_RESET_FETCH:
               if (fetch_ready)
                  state <= RIVM_ST_IDLE;
            RIVM_ST_IDLE:
               if (take)
                  state <= RIVM_ST_IRQ_FETCH;
            RIVM_ST_IRQ_FETCH:
               if (fetch_ready)
                  state <= RIVM_ST_IDLE;
         endcase
      end
   end

   // fuse is a strap: caught by a clocked edge just after release
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         boot_reset_active <= 1'b0;
      else if (in_fuse_phase)
         boot_reset_active <= (boot_reset_select_fuse == RIVM_FUSE_PROGRAMMED);
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         fetch_valid <= 1'b0;
      else if (in_fuse_phase || take)
         fetch_valid <= 1'b1;
      else if (accept)
         fetch_valid <= 1'b0;
   end

   // payload frozen while the core stalls the fetch
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         fetch <= '0;
      else if (in_fuse_phase)
      begin
         fetch.is_reset  <= 1'b1;
         fetch.relocated <= 1'b0;
         fetch.vec_no    <= RIVM_RESET_VEC_NO;
         fetch.addr      <= reset_target(boot_reset_select_fuse);
      end
      else if (take)
      begin
         fetch.is_reset  <= 1'b0;
         fetch.relocated <= vector_table_select_bit;
         fetch.vec_no    <= RIVM_VNO_W'(win_idx) + RIVM_FIRST_IRQ_VEC_NO;
         fetch.addr      <= vec_target(win_idx, vector_table_select_bit);
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         win_held <= '0;
      else if (take)
         win_held <= win_onehot;
   end

   // one-cycle acknowledge lets the source drop its flag
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         irq_ack <= '0;
      else if (accept && state == RIVM_ST_IRQ_FETCH)
         irq_ack <= win_held;
      else
         irq_ack <= '0;
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   // the edge that releases reset still sees the strap state: leave it out
   chk_reset_first_fetch: assert property (
      in_fuse_phase && rstn |=> fetch_valid && fetch.is_reset && fetch.vec_no == RIVM_RESET_VEC_NO)
      else $error("reset fetch not issued after reset release");

   chk_reset_addr_zero: assert property (
      fetch_valid && fetch.is_reset && !boot_reset_active |-> fetch.addr == RIVM_RESET_ADDR)
      else $error("unrelocated reset fetch not at address zero");

   chk_boot_reset_addr: assert property (
      fetch_valid && fetch.is_reset && boot_reset_active |-> fetch.addr == BOOT_START)
      else $error("programmed fuse reset fetch not at boot start");

   // same release edge hazard as above
   chk_fuse_polarity: assert property (
      in_fuse_phase && rstn |=> boot_reset_active == !$past(boot_reset_select_fuse))
      else $error("boot fuse polarity wrong");

   chk_fetch_only_taken: assert property (
      fetch_valid && !$past(fetch_valid) |-> $past(in_fuse_phase) || $past(take))
      else $error("vector fetched without a taken interrupt");

   chk_lowest_first: assert property (
      take |-> win_onehot == (pending & (~pending + 1'b1)))
      else $error("a higher vector number won over a lower one");

   chk_fetch_holds: assert property (
      fetch_valid && !fetch_ready |=> fetch_valid && $stable(fetch))
      else $error("fetch dropped or changed while stalled");

   chk_ack_single_pulse: assert property (
      accept && !fetch.is_reset |=> $onehot(irq_ack) ##1 irq_ack == '0)
      else $error("acknowledge not a single one-hot pulse");

   chk_first_reloc: assert property (
      fetch_valid && fetch.relocated && fetch.vec_no == RIVM_FIRST_IRQ_VEC_NO
      |-> fetch.addr == RIVM_PC_W'(BOOT_START + RIVM_FIRST_RELOC_OFS / RIVM_PC_W'(
          RIVM_VEC_WORDS_LARGE / VEC_WORDS)))
      else $error("first relocated vector misplaced");

   // ack goes to the source whose vector was just accepted
   chk_ack_matches_vec: assert property (
      accept && !fetch.is_reset
      |=> irq_ack == NUM_SRC'(1) << ($past(fetch.vec_no) - RIVM_FIRST_IRQ_VEC_NO))
      else $error("acknowledge sent to the wrong source");

   chk_ack_source: assert property (
      irq_ack != '0 |-> $past(accept) && !$past(fetch.is_reset))
      else $error("acknowledge without an accepted interrupt fetch");

   chk_valid_drops: assert property (
      accept |=> !fetch_valid)
      else $error("fetch still offered after acceptance");

   chk_valid_state: assert property (
      fetch_valid == (state == RIVM_ST_RESET_FETCH || state == RIVM_ST_IRQ_FETCH))
      else $error("fetch offer does not match the sequencer state");

   // a stale payload must not change between offers
   chk_payload_kept: assert property (
      !fetch_valid && !take && !in_fuse_phase |=> $stable(fetch))
      else $error("fetch payload changed between offers");

   chk_win_pending: assert property (
      take |-> $onehot(win_onehot) && (win_onehot & ~pending) == '0)
      else $error("winner is not a single pending request");

   chk_vec_no_range: assert property (
      fetch_valid && !fetch.is_reset
      |-> fetch.vec_no >= RIVM_FIRST_IRQ_VEC_NO && fetch.vec_no <= RIVM_LAST_IRQ_VEC_NO)
      else $error("interrupt vector number out of range");

   // the select bit is a table move only; reset stays put
   chk_reset_not_moved: assert property (
      fetch_valid && fetch.is_reset |-> !fetch.relocated)
      else $error("select bit moved the reset fetch");

   chk_select_latched: assert property (
      take |=> fetch.relocated == $past(vector_table_select_bit))
      else $error("select bit not captured at the take");

   // strap is read once per reset, never again
   chk_boot_flag_once: assert property (
      !in_fuse_phase |=> $stable(boot_reset_active))
      else $error("boot flag changed after the strap phase");

   generate
      if (VEC_WORDS == RIVM_VEC_WORDS_LARGE && NUM_SRC == RIVM_NUM_SRC)
      begin : g_large_table
         for (genvar i = 0; i < NUM_SRC; i++)
         begin : g_src
            chk_table_addr: assert property (
               fetch_valid && !fetch.relocated && !fetch.is_reset
               && fetch.vec_no == RIVM_VNO_W'(i) + RIVM_FIRST_IRQ_VEC_NO
               |-> fetch.addr == RIVM_VEC_ADDR[i])
               else $error("vector address differs from table");

            chk_reloc_add: assert property (
               fetch_valid && fetch.relocated && !fetch.is_reset
               && fetch.vec_no == RIVM_VNO_W'(i) + RIVM_FIRST_IRQ_VEC_NO
               |-> fetch.addr == RIVM_PC_W'(BOOT_START + RIVM_VEC_ADDR[i]))
               else $error("relocated vector is not table plus boot start");
         end
      end
      if (VEC_WORDS == RIVM_VEC_WORDS_SMALL && BOOT_START == RIVM_BOOT_START_SMALL)
      begin : g_small_table
         chk_small_range: assert property (
            fetch_valid && fetch.relocated && !fetch.is_reset
            |-> fetch.addr >= RIVM_SMALL_FIRST_RELOC && fetch.addr <= RIVM_SMALL_LAST_RELOC)
            else $error("small relocated vector out of boot range");

         chk_small_last: assert property (
            fetch_valid && fetch.relocated && fetch.vec_no == RIVM_LAST_IRQ_VEC_NO
            |-> fetch.addr == RIVM_SMALL_LAST_RELOC)
            else $error("small last relocated vector misplaced");
      end
   endgenerate

   cov_boot_reset: cover property (
      in_fuse_phase && boot_reset_select_fuse == RIVM_FUSE_PROGRAMMED ##1 accept);

   cov_reloc_irq: cover property (
      take && vector_table_select_bit ##[1:4] accept);

   cov_stalled_fetch: cover property (
      fetch_valid && !fetch_ready [*3] ##1 accept);

   cov_two_pending: cover property (
      take && $countones(pending) > 1);

   cov_last_source: cover property (
      take && win_onehot[NUM_SRC-1]);

endmodule // rivm_vector_map

// *** tb/rivm_core_model.sv ***
// core fetch side model: accepts vector fetches and masks interrupts on entry
`timescale 1ns/10ps
module rivm_core_model
   import rivm_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         rstn,
   input  wire logic         slow,
   input  wire logic         irq_on,
   input  wire logic         fetch_valid,
   input  wire rivm_fetch_s  fetch,
   output logic              fetch_ready,
   output logic              cpu_irq_enable,
   output rivm_fetch_s       got,
   output int                n_got
);
   logic [1:0] cnt;
   logic       held;

   // a slow core accepts one cycle in four, so the offer must stand meanwhile
   assign fetch_ready    = !slow || cnt == 2'h3;
   // entry clears the global enable until software sets it again
   assign cpu_irq_enable = irq_on && !held;

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt   <= 2'h0;
         held  <= 1'b0;
         n_got <= 0;
         got   <= '0;
      end
      else
      begin
         cnt <= cnt + 2'h1;
         if (fetch_valid && fetch_ready)
         begin
            got   <= fetch;
            n_got <= n_got + 1;
            held  <= 1'b1;
         end
         else if (!irq_on)
            held <= 1'b0;
      end
   end
endmodule // rivm_core_model

// *** tb/test_reset_irq_vector_map.sv ***
// self-checking bench for the reset and interrupt vector map
`timescale 1ns/10ps
module test_reset_irq_vector_map
   import rivm_pkg::*;
;
   logic                    mclk   = 1'b0;
   logic                    rstn   = 1'b0;
   logic                    fuse   = 1'b1;
   logic                    sel    = 1'b0;
   logic                    slow   = 1'b0;
   logic                    irq_on = 1'b0;
   logic [RIVM_NUM_SRC-1:0] mask   = '0;
   logic [RIVM_NUM_SRC-1:0] req    = '0;
   logic [RIVM_NUM_SRC-1:0] ack;
   logic                    fetch_ready;
   logic                    fetch_valid;
   logic                    cpu_irq_enable;
   logic                    boot_act;
   rivm_fetch_s             fetch;
   rivm_fetch_s             got;
   int                      n_got;
   logic                    fetch_ready_s;
   logic                    fetch_valid_s;
   logic                    cpu_irq_enable_s;
   logic                    boot_act_s;
   logic [RIVM_NUM_SRC-1:0] ack_s;
   rivm_fetch_s             fetch_s;
   rivm_fetch_s             got_s;
   int                      n_got_s;
   int                      err_total = 0;
   int                      cmp_count = 0;

   always #20 mclk = ~mclk;

   rivm_vector_map dut_u (.mclk(mclk), .rstn(rstn), .boot_reset_select_fuse(fuse),
      .vector_table_select_bit(sel), .cpu_irq_enable(cpu_irq_enable),
      .irq_enable_mask(mask), .irq_req(req), .fetch_ready(fetch_ready),
      .fetch_valid(fetch_valid), .fetch(fetch), .irq_ack(ack), .boot_reset_active(boot_act));

   rivm_core_model core_u (.mclk(mclk), .rstn(rstn), .slow(slow), .irq_on(irq_on),
      .fetch_valid(fetch_valid), .fetch(fetch), .fetch_ready(fetch_ready),
      .cpu_irq_enable(cpu_irq_enable), .got(got), .n_got(n_got));

   // smaller one-word part, run in lock step with the larger one
   rivm_vector_map #(.BOOT_START(RIVM_BOOT_START_SMALL), .VEC_WORDS(RIVM_VEC_WORDS_SMALL))
      dut_small_u (.mclk(mclk), .rstn(rstn), .boot_reset_select_fuse(fuse),
      .vector_table_select_bit(sel), .cpu_irq_enable(cpu_irq_enable_s),
      .irq_enable_mask(mask), .irq_req(req), .fetch_ready(fetch_ready_s),
      .fetch_valid(fetch_valid_s), .fetch(fetch_s), .irq_ack(ack_s),
      .boot_reset_active(boot_act_s));

   rivm_core_model core_small_u (.mclk(mclk), .rstn(rstn), .slow(slow), .irq_on(irq_on),
      .fetch_valid(fetch_valid_s), .fetch(fetch_s), .fetch_ready(fetch_ready_s),
      .cpu_irq_enable(cpu_irq_enable_s), .got(got_s), .n_got(n_got_s));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      cmp_count++;
      if (exp !== seen)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // bounded wait; sampled on the falling edge where outputs have settled
   task automatic wait_got(input int want);
      int k;
      k = 0;
      while (n_got != want && k < 50)
      begin
         @(negedge mclk);
         k++;
      end
      chk("fetch count", want, n_got);
   endtask

   task automatic do_reset(input logic f, input logic [RIVM_PC_W-1:0] exp);
      @(posedge mclk);
      rstn <= 1'b0;
      fuse <= f;
      repeat (20) @(posedge mclk);
      chk("valid in reset", 0, fetch_valid);
      rstn <= 1'b1;
      wait_got(1);
      chk("reset fetch", {1'b1, 1'b0, RIVM_RESET_VEC_NO, exp}, got);
      chk("boot flag", !f, boot_act);
      chk("small reset", {1'b1, 1'b0, RIVM_RESET_VEC_NO,
          (f ? RIVM_RESET_ADDR : RIVM_BOOT_START_SMALL)}, got_s);
      chk("small boot flag", !f, boot_act_s);
   endtask

   task automatic take(input logic s, input logic [24:0] m, input logic [24:0] r, input int w);
      int                   base;
      logic [RIVM_PC_W-1:0] a;
      logic [RIVM_PC_W-1:0] a_small;
      base = n_got;
      a = (s ? RIVM_BOOT_START_LARGE : 13'h0000) + RIVM_VEC_ADDR[w];
      a_small = (s ? RIVM_SMALL_FIRST_RELOC : 13'h0001) + 13'(w);
      @(posedge mclk);
      sel    <= s;
      mask   <= m;
      req    <= r;
      irq_on <= 1'b1;
      wait_got(base + 1);
      chk("vector fetch", {1'b0, s, 5'(w + 2), a}, got);
      chk("ack pulse", 25'h1 << w, ack);
      chk("small vector", {1'b0, s, 5'(w + 2), a_small}, got_s);
      chk("small ack", 25'h1 << w, ack_s);
      @(negedge mclk);
      chk("ack drop", 0, ack);
      chk("valid drop", 0, fetch_valid);
      @(posedge mclk);
      irq_on <= 1'b0;
      req    <= '0;
   endtask

   // pending but not allowed: no vector location may be fetched
   task automatic quiet(input logic on, input logic [24:0] m);
      int base;
      base = n_got;
      @(posedge mclk);
      irq_on <= on;
      mask   <= m;
      req    <= '1;
      repeat (10) @(negedge mclk);
      chk("no fetch", base, n_got);
      @(posedge mclk);
      irq_on <= 1'b0;
      req    <= '0;
   endtask

   initial
   begin
      #(40 * 5000);
      err_total++;
      final_report;
   end

   initial
   begin
      do_reset(1'b1, RIVM_RESET_ADDR);
      for (int i = 0; i < RIVM_NUM_SRC; i++)
      begin
         slow <= i[0];
         take(1'b0, '1, 25'h1 << i, i);
      end
      for (int i = 0; i < RIVM_NUM_SRC; i++)
         take(1'b1, '1, 25'h1 << i, i);
      take(1'b0, 25'h0000088, '1, 3);
      take(1'b0, '1, 25'h1800000, 23);
      quiet(1'b1, '0);
      quiet(1'b0, '1);
      do_reset(1'b0, RIVM_BOOT_START_LARGE);
      take(1'b1, '1, 25'h1, 0);
      take(1'b0, '1, 25'h1, 0);
      final_report;
   end
endmodule // test_reset_irq_vector_map
